// file: hw/gpcm_top.sv
// Three-port pin configuration, output data, wake masking and timer routing
`timescale 1ns/1ps
module gpcm_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pad side, 24 pins, port a in bits 7:0
  input wire logic [23:0] pad_in,
  output logic [23:0] pad_out,
  output logic [23:0] pad_oe,
  output logic [23:0] pad_pull_up,
  output logic [23:0] pad_pull_down,
  // Peripheral alternate outputs and their valid flags
  input wire logic [23:0] serial_alt_level,
  input wire logic [23:0] serial_alt_valid,
  input wire logic [3:0] timer_channel_level,
  // Conditioned inputs to peripherals
  output logic [23:0] periph_in_level,
  // Wake event pulse
  output logic wake_event
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // Mode nibbles, one 32-bit word per port (low word pins 3:0, high 7:4)
  logic [31:0] mode_reg [gpcm_pkg::PORTS];
  // Output data per port
  logic [7:0] out_reg [gpcm_pkg::PORTS];
  // Wake masks per port
  logic [7:0] wake_reg [gpcm_pkg::PORTS];
  // Timer route bits 7:4 and channel enables 3:0
  logic [3:0] route_reg;
  logic [3:0] tim_en_reg;
  // Pad synchronisers
  logic [23:0] pad_meta_reg;
  logic [23:0] pad_sync_reg;
  // Previous conditioned input for change detection
  logic [23:0] in_prev_reg;
  // Decoded write target
  logic [1:0] wport;
  logic [7:0] wofs;
  logic wport_ok;
  // Combinational pin results
  gpcm_pkg::gpcm_pad_type pad_c [24];
  logic [23:0] in_level_c;
  logic [23:0] alt_level_c;
  logic [23:0] alt_valid_c;

  //////////////////////////////////////////////////////////////////////////////
  // Address split

  // RULE_11: port number from address block
  always_comb begin
    wport = 2'h3;
    wofs = reg_addr;
    wport_ok = 1'b0;
    if (reg_addr < gpcm_pkg::PORT_STRIDE) begin
      wport = 2'h0;
      wport_ok = 1'b1;
    end else if (reg_addr < 8'(2 * gpcm_pkg::PORT_STRIDE)) begin
      wport = 2'h1;
      wofs = reg_addr - gpcm_pkg::PORT_STRIDE;
      wport_ok = 1'b1;
    end else if (reg_addr < 8'(3 * gpcm_pkg::PORT_STRIDE)) begin
      wport = 2'h2;
      wofs = reg_addr - 8'(2 * gpcm_pkg::PORT_STRIDE);
      wport_ok = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode registers

  // Mode words are written as whole 16-bit halves
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // RULE_20: all pins floating input after reset
      for (int p = 0; p < gpcm_pkg::PORTS; p++) begin
        mode_reg[p] <= {gpcm_pkg::MODE_NIBBLES_RESET, gpcm_pkg::MODE_NIBBLES_RESET};
      end
    end else if (reg_wr && wport_ok) begin
      // RULE_01: low register pins 3:0, high 7:4
      if (wofs == gpcm_pkg::OFS_MODE_LOW) begin
        mode_reg[wport][15:0] <= reg_wdata[15:0];
      end else if (wofs == gpcm_pkg::OFS_MODE_HIGH) begin
        mode_reg[wport][31:16] <= reg_wdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output data register and its aliases

  // Direct write, set alias and clear alias share one register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < gpcm_pkg::PORTS; p++) begin
        out_reg[p] <= gpcm_pkg::BYTE_RESET;
      end
    end else if (reg_wr && wport_ok) begin
      if (wofs == gpcm_pkg::OFS_OUTPUT) begin
        out_reg[wport] <= reg_wdata[7:0];
      end else if (wofs == gpcm_pkg::OFS_SET) begin
        // RULE_14: ones set bits; RULE_21: zeros keep
        out_reg[wport] <= out_reg[wport] | reg_wdata[7:0];
      end else if (wofs == gpcm_pkg::OFS_CLEAR) begin
        // RULE_13: ones clear bits; RULE_21: zeros keep
        out_reg[wport] <= out_reg[wport] & ~reg_wdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake masks and timer routing

  // Wake mask per port
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < gpcm_pkg::PORTS; p++) begin
        wake_reg[p] <= gpcm_pkg::BYTE_RESET;
      end
    end else if (reg_wr && wport_ok && wofs == gpcm_pkg::OFS_WAKE) begin
      wake_reg[wport] <= reg_wdata[7:0];
    end
  end

  // Timer route and enable bits, mirrored here so routing is local
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      route_reg <= 4'h0;
      tim_en_reg <= 4'h0;
    end else if (reg_wr && reg_addr == gpcm_pkg::OFS_TIMER_ROUTE) begin
      route_reg <= reg_wdata[gpcm_pkg::ROUTE_LSB +: 4];
    end else if (reg_wr && reg_addr == gpcm_pkg::OFS_TIMER_ENABLE) begin
      tim_en_reg <= reg_wdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alternate source arbitration

  // Start from serial sources, then let enabled timer channels override
  always_comb begin
    alt_level_c = serial_alt_level;
    alt_valid_c = serial_alt_valid;
    for (int c = 0; c < 4; c++) begin
      // RULE_16: enables gate each channel
      if (tim_en_reg[c]) begin
        // RULE_18: route bit picks port b line; RULE_17: timer wins
        if (route_reg[c]) begin
          alt_level_c[8 + int'(gpcm_pkg::CH_LINE_B[c])] = timer_channel_level[c];
          alt_valid_c[8 + int'(gpcm_pkg::CH_LINE_B[c])] = 1'b1;
        end else begin
          alt_level_c[int'(gpcm_pkg::CH_LINE_A[c])] = timer_channel_level[c];
          alt_valid_c[int'(gpcm_pkg::CH_LINE_A[c])] = 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin decoders

  // Pad inputs pass two flops; only the second is read by logic
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_meta_reg <= 24'h000000;
      pad_sync_reg <= 24'h000000;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // RULE_10: one decoder per pin picks the single output source
  genvar g;
  generate
    for (g = 0; g < 24; g++) begin : g_pin
      gpcm_pin u_pin (
        .mode(mode_reg[g / 8][4 * (g % 8) +: 4]),
        .out_bit(out_reg[g / 8][g % 8]),
        .alt_valid(alt_valid_c[g]),
        .alt_level(alt_level_c[g]),
        .pad_sync(pad_sync_reg[g]),
        .pad(pad_c[g]),
        .in_level(in_level_c[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registered pad and peripheral outputs

  // Outputs come from flops so pads see no glitch from decode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_out <= 24'h000000;
      pad_oe <= 24'h000000;
      pad_pull_up <= 24'h000000;
      pad_pull_down <= 24'h000000;
      periph_in_level <= 24'h000000;
    end else begin
      for (int i = 0; i < 24; i++) begin
        pad_out[i] <= pad_c[i].drive_level;
        pad_oe[i] <= pad_c[i].drive_oe;
        pad_pull_up[i] <= pad_c[i].pull_up;
        pad_pull_down[i] <= pad_c[i].pull_down;
      end
      // RULE_09: conditioned input to peripherals
      periph_in_level <= in_level_c;
    end
  end

  // RULE_15: masked change on any pin gives a wake pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_prev_reg <= 24'hFFFFFF;
      wake_event <= 1'b0;
    end else begin
      in_prev_reg <= in_level_c;
      // RULE_09: wake detector only for enabled pins
      wake_event <= |((in_level_c ^ in_prev_reg) & {wake_reg[2], wake_reg[1], wake_reg[0]});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  // Data stands only in the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == gpcm_pkg::OFS_TIMER_ROUTE) begin
      reg_rdata <= {24'h000000, route_reg, 4'h0};
    end else if (reg_addr == gpcm_pkg::OFS_TIMER_ENABLE) begin
      reg_rdata <= {28'h0000000, tim_en_reg};
    end else if (wport_ok) begin
      case (wofs)
        gpcm_pkg::OFS_MODE_LOW: reg_rdata <= {16'h0000, mode_reg[wport][15:0]};
        gpcm_pkg::OFS_MODE_HIGH: reg_rdata <= {16'h0000, mode_reg[wport][31:16]};
        // RULE_12: live pin level, analog pins read one
        gpcm_pkg::OFS_INPUT: reg_rdata <= {24'h000000, in_level_c[8 * wport +: 8]};
        gpcm_pkg::OFS_OUTPUT: reg_rdata <= {24'h000000, out_reg[wport]};
        gpcm_pkg::OFS_WAKE: reg_rdata <= {24'h000000, wake_reg[wport]};
        // Aliases are write-only and read zero
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// file: hw/gpcm_pkg.sv
// Package of constants and types for the three-port pin configuration and multiplexing block
//
// Operation
// RULE_01: Each pin has its own 4-bit mode
// RULE_02: Mode 0x0 analog, input reads one
// RULE_03: Mode 0x4 floating input, driver off
// RULE_04: Mode 0x8 pulled input, output bit picks
// RULE_05: Mode 0x1 push-pull from output register
// RULE_06: Mode 0x5 open-drain from output register
// RULE_07: Mode 0x9 push-pull from peripheral
// RULE_08: Mode 0xD open-drain from peripheral
// RULE_09: Conditioned input feeds register, peripherals, wake
// RULE_10: One output source, disabled for inputs
// RULE_11: Three ports of eight, bit equals pin
// RULE_12: Input register reads pin level
// RULE_13: Clear alias clears bits written one
// RULE_14: Set alias sets bits written one
// RULE_15: Wake mask selects pins causing wake
// RULE_16: Timer route bits and enables steer
// RULE_17: Enabled timer output beats serial output
// RULE_18: Route bits pick port A or B lines
// RULE_19: Alternate pin without peripheral drives zero
// RULE_20: Reset returns every mode to floating input
// RULE_21: Zero bits in aliases change nothing
package gpcm_pkg;

  // Geometry
  localparam int PORTS = 3;
  localparam int PINS = 8;
  localparam int ADDR_W = 8;

  // Mode codes
  localparam logic [3:0] MODE_ANALOG = 4'h0;
  localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
  localparam logic [3:0] MODE_IN_PULL = 4'h8;
  localparam logic [3:0] MODE_OUT_PP = 4'h1;
  localparam logic [3:0] MODE_OUT_OD = 4'h5;
  localparam logic [3:0] MODE_ALT_PP = 4'h9;
  localparam logic [3:0] MODE_ALT_OD = 4'hD;

  // Reset values
  localparam logic [15:0] MODE_NIBBLES_RESET = 16'h4444;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Register offsets within a port block; port block stride
  localparam logic [ADDR_W-1:0] OFS_MODE_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INPUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h18;
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h20;
  // Timer routing registers, after the three port blocks
  localparam logic [ADDR_W-1:0] OFS_TIMER_ROUTE = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_TIMER_ENABLE = 8'h64;

  // Timer route field position (bits 4 to 7)
  localparam int ROUTE_LSB = 4;
  // Port A / B line per timer channel, route bit clear / set
  localparam logic [2:0] CH_LINE_A [4] = '{3'h0, 3'h3, 3'h1, 3'h2};
  localparam logic [2:0] CH_LINE_B [4] = '{3'h1, 3'h2, 3'h3, 3'h4};

  // One pin's pad controls
  typedef struct packed {
    logic drive_oe;
    logic drive_level;
    logic pull_up;
    logic pull_down;
    logic input_on;
  } gpcm_pad_type;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpcm_bus_type;

endpackage

// file: hw/gpcm_pin.sv
// Single pin mode decoder: pad drive, pulls and conditioned input
`timescale 1ns/1ps
module gpcm_pin (
  // Configuration
  input wire logic [3:0] mode,
  input wire logic out_bit,
  // Alternate source
  input wire logic alt_valid,
  input wire logic alt_level,
  // Synchronised pad level
  input wire logic pad_sync,
  // Results
  output gpcm_pkg::gpcm_pad_type pad,
  output logic in_level
);

  // Decode the mode nibble into pad controls
  always_comb begin
    pad = '0;
    in_level = pad_sync;
    case (mode)
      // RULE_02: analog forces input high
      gpcm_pkg::MODE_ANALOG: begin
        in_level = 1'b1;
      end
      // RULE_03: floating input, no pull
      gpcm_pkg::MODE_IN_FLOAT: begin
        pad.input_on = 1'b1;
      end
      // RULE_04: pull direction from output bit
      gpcm_pkg::MODE_IN_PULL: begin
        pad.input_on = 1'b1;
        pad.pull_up = out_bit;
        pad.pull_down = ~out_bit;
      end
      // RULE_05: push-pull from output bit
      gpcm_pkg::MODE_OUT_PP: begin
        pad.input_on = 1'b1;
        pad.drive_oe = 1'b1;
        pad.drive_level = out_bit;
      end
      // RULE_06: open-drain drives only low
      gpcm_pkg::MODE_OUT_OD: begin
        pad.input_on = 1'b1;
        pad.drive_oe = ~out_bit;
      end
      // RULE_07: push-pull from peripheral; RULE_19: zero if none
      gpcm_pkg::MODE_ALT_PP: begin
        pad.input_on = 1'b1;
        pad.drive_oe = 1'b1;
        pad.drive_level = alt_valid & alt_level;
      end
      // RULE_08: open-drain from peripheral
      gpcm_pkg::MODE_ALT_OD: begin
        pad.input_on = 1'b1;
        pad.drive_oe = ~(alt_valid & alt_level);
      end
      // Undefined codes behave as a floating input, the safest pad state
      default: begin
        pad.input_on = 1'b1;
      end
    endcase
  end

endmodule

// file: test/gpcm_props.sv
// Port-level assertion checker for the pin block, bound into its top module
`timescale 1ns/1ps
module gpcm_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pads and conditioned inputs
  input wire logic [23:0] pad_in,
  input wire logic [23:0] pad_oe,
  input wire logic [23:0] pad_pull_up,
  input wire logic [23:0] pad_pull_down,
  input wire logic [23:0] periph_in_level,
  input wire logic wake_event
);
  logic [23:0] pad_prev;  // Pads one edge ago
  logic [3:0] age;  // Edges since pads moved, saturating
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////
  // Pad quiet timer: level checks wait out the synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_prev <= 24'h000000;
      age <= 4'h0;
    end else begin
      pad_prev <= pad_in;
      age <= (pad_in != pad_prev) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)  // idle
    else $error("read data outside its slot");
  AST_ALIAS_READ_ZERO: assert property (  // alias
    reg_rd && reg_addr == gpcm_pkg::OFS_SET |=> reg_rdata == 32'h0)
    else $error("set alias read not zero");
  AST_PULL_EXCL: assert property ((pad_pull_up & pad_pull_down) == 24'h000000)  // pulls
    else $error("pull up and down together");
  AST_NO_PULL_DRIVEN: assert property ((pad_oe & (pad_pull_up | pad_pull_down)) == 24'h000000)  // drive
    else $error("pull while driving");
  AST_RESET_FLOAT: assert property (  // reset
    $rose(reset_n) |-> (pad_oe | pad_pull_up | pad_pull_down) == 24'h0)
    else $error("pins not floating after reset");
  AST_IN_HIGH: assert property (reg_rd && reg_addr == gpcm_pkg::OFS_INPUT && pad_in == pad_prev && age > 4'h3
    |=> (reg_rdata[7:0] & $past(pad_in[7:0])) == $past(pad_in[7:0]))  // level
    else $error("high pin read as low");
  AST_PERIPH_HIGH: assert property (
    pad_in == pad_prev && age > 4'h4 |-> (periph_in_level & pad_in) == pad_in)
    else $error("high pin not passed to peripherals");
  AST_WAKE_PULSE: assert property (wake_event |=> !wake_event)  // pulse
    else $error("wake event longer than one cycle");
  AST_WAKE_CAUSE: assert property (wake_event |-> age < 4'h6)  // cause
    else $error("wake event without pin change");

  // Main scenarios seen
  cover property (wake_event);
  cover property (reg_rd && reg_addr == gpcm_pkg::OFS_INPUT && age > 4'h3);
  cover property (pad_oe != 24'h000000);
endmodule

bind gpcm_top gpcm_props u_props (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
  .pad_pull_down(pad_pull_down), .periph_in_level(periph_in_level), .wake_event(wake_event));

// file: test/gpcm_pad_model.sv
// Outside world of the 24 pins: resolves each wire level
`timescale 1ns/1ps
module gpcm_pad_model (
  // Device side
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe,
  input wire logic [23:0] pad_pull_up,
  input wire logic [23:0] pad_pull_down,
  // Outside drivers
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_lvl,
  // Resolved level
  output logic [23:0] pad_level
);
  ////////////////////////////////////////////////////////////////
  // Floating wire shows the inverse of the outside level, not a kind 0
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pad_oe[i]) begin
        pad_level[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_level[i] = ext_lvl[i];
      end else if (pad_pull_up[i] || pad_pull_down[i]) begin
        pad_level[i] = pad_pull_up[i];
      end else begin
        pad_level[i] = ~ext_lvl[i];
      end
    end
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the three-port pin block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, periph_in_level;
  logic [23:0] sa_lvl = 24'h0, sa_vld = 24'h0, ext_en = 24'h0, ext_lvl = 24'h0;
  logic [3:0] t_lvl = 4'h0;
  logic wake_event;
  // Shadow of software writes
  logic [95:0] m_sh = {24{4'h4}};
  logic [23:0] o_sh = 24'h0;
  logic [7:0] rt_sh = 8'h00, en_sh = 8'h00;
  // Timer pin per channel, route bit clear or set
  int la [4] = '{0, 3, 1, 2};
  int lb [4] = '{1, 2, 3, 4};
  logic [7:0] rt_t [5] = '{8'h00, 8'h00, 8'hF0, 8'hA0, 8'h50};
  logic [7:0] en_t [5] = '{8'h00, 8'h0F, 8'h0F, 8'h05, 8'h0A};
  int failures = 0, n_compared = 0;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  gpcm_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .serial_alt_level(sa_lvl),
    .serial_alt_valid(sa_vld), .timer_channel_level(t_lvl), .periph_in_level(periph_in_level),
    .wake_event(wake_event));
  gpcm_pad_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_level(pad_in));

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ad(input int p, input logic [7:0] o);
    return 8'(p) * gpcm_pkg::PORT_STRIDE + o;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic wm(input int p, input logic [15:0] lo, input logic [15:0] hi);
    wr(ad(p, gpcm_pkg::OFS_MODE_LOW), {16'h0, lo});
    wr(ad(p, gpcm_pkg::OFS_MODE_HIGH), {16'h0, hi});
    m_sh[32*p +: 32] = {hi, lo};
  endtask
  task automatic so(input int p, input logic [7:0] v, input logic s);
    wr(ad(p, s ? gpcm_pkg::OFS_SET : gpcm_pkg::OFS_CLEAR), {24'h0, v});
    o_sh[8*p +: 8] = s ? (o_sh[8*p +: 8] | v) : (o_sh[8*p +: 8] & ~v);
  endtask
  // Expected pad controls from the shadow state
  task automatic chk_pads();
    logic [23:0] eo, ev, eu, ed;
    logic [3:0] md;
    logic al, ob;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 24; i++) begin
      md = m_sh[4*i +: 4];
      ob = o_sh[i];
      al = sa_lvl[i] & sa_vld[i];
      for (int c = 0; c < 4; c++) begin
        if (en_sh[c] && i == (rt_sh[4+c] ? 8 + lb[c] : la[c])) al = t_lvl[c];
      end
      eo[i] = (md == 4'h1) || (md == 4'h9) || (md == 4'h5 && !ob) || (md == 4'hD && !al);
      ev[i] = (md == 4'h1 && ob) || (md == 4'h9 && al);
      eu[i] = (md == 4'h8) && ob;
      ed[i] = (md == 4'h8) && !ob;
    end
    chk("pad_oe", {8'h0, eo}, {8'h0, pad_oe});
    chk("pad_out", {8'h0, ev}, {8'h0, pad_out & pad_oe});
    chk("pad_pull_up", {8'h0, eu}, {8'h0, pad_pull_up});
    chk("pad_pull_down", {8'h0, ed}, {8'h0, pad_pull_down});
  endtask
  task automatic wait_wake(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      #1 seen = seen | (wake_event === 1'b1);
    end
    chk("wake_event", {31'h0, e}, {31'h0, seen});
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(ad(p, gpcm_pkg::OFS_MODE_LOW), 32'h00004444, "mode_low");  // floating
      rd(ad(p, gpcm_pkg::OFS_MODE_HIGH), 32'h00004444, "mode_high");  // floating
    end
    // Every mode on port a, output byte through both aliases
    wm(0, 16'hD951, 16'h8840);  // nibble per pin
    rd(ad(0, gpcm_pkg::OFS_MODE_LOW), 32'h0000D951, "mode_low");  // readback
    so(0, 8'hFF, 1'b1);  // set
    so(0, 8'h4A, 1'b0);  // clear
    so(0, 8'h00, 1'b1);  // zero set
    rd(ad(0, gpcm_pkg::OFS_OUTPUT), 32'h000000B5, "output");  // aliases
    chk_pads();  // modes
    // Pads have been quiet for several edges, so the level checker sees this read
    rd(ad(0, gpcm_pkg::OFS_INPUT), 32'h000000B1, "input");  // port a levels
    wr(ad(0, gpcm_pkg::OFS_OUTPUT), 32'h0000003C);  // direct write
    o_sh[7:0] = 8'h3C;
    chk_pads();  // flipped bits
    // Alternate pins shared by timer and serial controllers
    wm(0, 16'h9999, 16'hD999);  // alternate
    wm(1, 16'h9999, 16'h9999);  // port b
    @(posedge ref_clk);
    sa_vld <= 24'h00F0F5;
    sa_lvl <= 24'hFF00FF;
    t_lvl <= 4'h6;
    for (int k = 0; k < 5; k++) begin
      rt_sh = rt_t[k];
      en_sh = en_t[k];
      wr(gpcm_pkg::OFS_TIMER_ROUTE, {24'h0, rt_sh});  // route
      wr(gpcm_pkg::OFS_TIMER_ENABLE, {24'h0, en_sh});  // enables
      chk_pads();  // routing
    end
    // Inputs on port c, then analog on its low half
    @(posedge ref_clk);
    ext_en <= 24'hFF0000;
    ext_lvl <= 24'h5A0000;
    repeat (4) @(posedge ref_clk);
    rd(ad(2, gpcm_pkg::OFS_INPUT), 32'h0000005A, "input");  // level
    wm(2, 16'h0000, 16'h4444);  // analog
    repeat (3) @(posedge ref_clk);
    rd(ad(2, gpcm_pkg::OFS_INPUT), 32'h0000005F, "input");  // reads one
    chk("periph_in", 32'h0000005F, {24'h0, periph_in_level[23:16]});  // peripherals
    // Wake on masked pin only
    wm(2, 16'h4444, 16'h4444);  // floating
    wr(ad(2, gpcm_pkg::OFS_WAKE), 32'h00000001);  // mask
    rd(ad(2, gpcm_pkg::OFS_WAKE), 32'h00000001, "wake_mask");  // readback
    @(posedge ref_clk);
    ext_lvl <= 24'h5B0000;
    wait_wake(1'b1);  // masked pin
    @(posedge ref_clk);
    ext_lvl <= 24'h590000;
    wait_wake(1'b0);  // unmasked pin
    // Read-only, alias and unmapped places
    wr(ad(2, gpcm_pkg::OFS_INPUT), 32'h000000FF);  // read only
    rd(ad(2, gpcm_pkg::OFS_INPUT), 32'h00000059, "input");  // unchanged
    rd(ad(1, gpcm_pkg::OFS_SET), 32'h0, "set_alias");  // write only
    rd(ad(0, gpcm_pkg::OFS_SET), 32'h0, "set_alias");  // write only
    wr(8'h70, 32'h000000FF);  // unmapped write
    rd(8'h70, 32'h0, "unmapped");  // no register
    tally_and_finish();
  end
endmodule
